//--- inc/lane_pkg.sv
// package: phases, cycle kinds and pin groups for the byte-lane signalling block
package lane_pkg;
  // ==========================================
  // bus phases and cycle kinds
  typedef enum logic [2:0] {PH_IDLE, PH_T1, PH_T2, PH_T3, PH_T4} phase_t;
  typedef enum logic [1:0] {K_WORD, K_HIGH, K_LOW, K_REFRESH} kind_t;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 20;
  localparam logic        LANE_ON  = 1'b0;
  localparam logic        LANE_OFF = 1'b1;
  // ==========================================
  // request from the bus unit
  typedef struct packed {
    logic              start;
    logic              write;
    logic              refresh;
    logic              narrow;
    logic [1:0]        bytes;   // bit1 upper, bit0 lower lane wanted
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;
  // pin group driven by the block
  typedef struct packed {
    logic              lane_o;
    logic              lane_oe;
    logic [DATA_W-1:0] ad_o;
    logic [DATA_W-1:0] ad_oe;
    logic              ale;
    logic              wr_lo_n;
    logic              wr_hi_n;
    logic              narrow_cycle_flag;
  } pins_t;
endpackage : lane_pkg

//--- hdl/lane_encode.sv
// lane encoder: cycle kind to upper-lane enable and address/data bit 0
module lane_encode
  import lane_pkg::*;
(
  input  wire logic [1:0] bytes,
  input  wire logic       refresh,
  input  wire logic       a0,
  output      kind_t      kind,
  output      logic       lane_n,
  output      logic       bit0
);
  // refresh takes priority over any byte request
  assign kind = refresh ? K_REFRESH :
                (bytes == 2'b11) ? K_WORD :
                (bytes == 2'b10) ? K_HIGH : K_LOW;
  assign lane_n = (kind == K_LOW || kind == K_REFRESH) ? LANE_OFF : LANE_ON;
  // a word transfer is forced even-aligned; refresh drives bit 0 high
  assign bit0 = (kind == K_WORD) ? 1'b0 :
                (kind == K_HIGH || kind == K_REFRESH) ? 1'b1 :
                1'b0;
endmodule : lane_encode

//--- hdl/lane_signalling.sv
// top: byte-lane, refresh and bus-size signalling over a four-phase bus cycle
// Behaviour
// - word transfer drives upper-lane enable low and bit 0 low.
// - high byte only drives enable low, bit 0 high, data on 15-8.
// - low byte only drives enable high, bit 0 low, data on 7-0.
// - refresh cycle drives enable high and bit 0 high together.
// - enable released with pull-up during bus-hold and reset.
// - separate high and low write strobes carry the same lane selection.
// - refresh drives the muxed bus only in t1, released t2 to t4.
// - bus-size flag asserted through t4 for 8-bit cycles, else low.
// - address in t1 on the muxed bus, data in t2 to t4.
// - address stays valid at the falling edge of the latch strobe.
module lane_signalling
  import lane_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              hold_grant,
  input  wire req_t              req,
  input  wire logic [DATA_W-1:0] ad_i,
  output      logic [ADDR_W-1:0] nonmux_address_bus,
  output      pins_t             pins,
  output      logic [DATA_W-1:0] rdata,
  output      logic              rdata_valid,
  output      logic              busy
);
  // ==========================================
  // state
  phase_t            ph_q, ph_d;
  req_t              cur_q;
  logic              lane_q, bit0_q, ale_q, ale_d;
  logic [DATA_W-1:0] rdata_q;
  logic              rvalid_q;
  logic              lane_w, bit0_w;
  logic              kind_lo;

  lane_encode u_enc (
    .bytes   (req.bytes),
    .refresh (req.refresh),
    .a0      (req.addr[0]),
    .kind    (),
    .lane_n  (lane_w),
    .bit0    (bit0_w)
  );

  // ==========================================
  // phase sequencing
  wire take = (ph_q == PH_IDLE || ph_q == PH_T4) && req.start && !hold_grant;
  always_comb begin
    ph_d = ph_q;
    case (ph_q)
      PH_IDLE: ph_d = take ? PH_T1 : PH_IDLE;
      PH_T1:   ph_d = PH_T2;
      PH_T2:   ph_d = PH_T3;
      PH_T3:   ph_d = PH_T4;
      PH_T4:   ph_d = take ? PH_T1 : PH_IDLE;
      default: ph_d = PH_IDLE;
    endcase
  end
  // latch strobe rises with t1 and falls at its end while the address still stands
  assign ale_d = take;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_q   <= PH_IDLE;
      cur_q  <= '0;
      lane_q <= LANE_OFF;
      bit0_q <= 1'b0;
      ale_q  <= 1'b0;
    end else begin
      ph_q  <= ph_d;
      ale_q <= ale_d;
      if (take) begin
        cur_q  <= req;
        lane_q <= lane_w;
        bit0_q <= bit0_w;
      end
    end
  end

  // ==========================================
  // read capture at the end of t4
  wire is_read = ph_q == PH_T4 && !cur_q.write && !cur_q.refresh;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= is_read;
      if (is_read) rdata_q <= ad_i;
    end
  end
  assign rdata       = rdata_q;
  assign rdata_valid = rvalid_q;
  assign busy        = ph_q != PH_IDLE;

  // ==========================================
  // pin decode
  wire in_cycle = ph_q != PH_IDLE && !hold_grant;
  wire in_t1    = ph_q == PH_T1;
  wire data_ph  = ph_q == PH_T2 || ph_q == PH_T3 || ph_q == PH_T4;
  wire wr_ph    = data_ph && cur_q.write && !cur_q.refresh;
  // high byte rides bits 15-8, low byte bits 7-0; the word is driven as is
  wire [DATA_W-1:0] addr_word = {cur_q.addr[DATA_W-1:1], bit0_q};
  wire [DATA_W-1:0] lane_mask = {{(DATA_W/2){!lane_q}}, {(DATA_W/2){!bit0_q}}};
  assign kind_lo = cur_q.refresh;

  // address only in t1, data after; refresh lets go after t1
  assign pins.ad_o = in_t1 ? addr_word : cur_q.wdata;
  assign pins.ad_oe = !in_cycle ? '0 :
                      in_t1 ? '1 :
                      (kind_lo ? '0 : (wr_ph ? lane_mask : '0));
  // released in hold and reset; the pad pull-up keeps it inactive
  assign pins.lane_o  = in_cycle ? lane_q : LANE_OFF;
  assign pins.lane_oe = in_cycle && arst_n;
  assign pins.ale     = ale_q && !hold_grant;
  // nonmux bus has no refresh meaning, so the strobes stay high on refresh
  assign pins.wr_hi_n = !(in_cycle && wr_ph && lane_q == LANE_ON);
  assign pins.wr_lo_n = !(in_cycle && wr_ph && !bit0_q);
  assign pins.narrow_cycle_flag = in_cycle && cur_q.narrow && !kind_lo;
  // refresh address on the nonmux bus is left undefined, outside logic uses bit 0
  assign nonmux_address_bus = cur_q.addr;
endmodule : lane_signalling

//--- tb/lane_signalling_checker.sv
// checker: lane codes, refresh release, strobes and size flag
module lane_signalling_checker
  import lane_pkg::*;
(
  input wire logic  clk,
  input wire logic  arst_n,
  input wire logic  hold_grant,
  input wire req_t  req,
  input wire pins_t pins,
  input wire logic  rdata_valid,
  input wire logic  busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // only idle takes are tracked; takes in t4 are left unchecked
  wire take = req.start && !busy && !hold_grant;
  chk_word_code: assert property (take && !req.refresh && req.bytes == 2'b11
    |=> !pins.lane_o && !pins.ad_o[0]) else $error("word code");
  chk_refresh_release: assert property (pins.ale && pins.lane_o && pins.ad_o[0]
    |=> (pins.ad_oe == '0) [*3]) else $error("refresh bus");
  chk_hold_release: assert property (hold_grant
    |-> !pins.lane_oe && pins.ad_oe == '0 && !pins.ale && pins.wr_hi_n && pins.wr_lo_n)
    else $error("hold");
  chk_strobe_high: assert property (!pins.wr_hi_n
    |-> !pins.lane_o && pins.lane_oe) else $error("hi strobe");
  chk_strobe_low: assert property (!pins.wr_lo_n |-> pins.ad_oe[0]) else $error("lo strobe");
  chk_ale_single: assert property (pins.ale |=> !pins.ale) else $error("ale");
  chk_lane_held: assert property (pins.ale |=> $stable(pins.lane_o) [*3]) else $error("lane");
  chk_narrow_flag: assert property (take && req.narrow && !req.refresh
    |=> pins.narrow_cycle_flag [*4]) else $error("size flag");
  chk_read_valid: assert property (take && !req.write && !req.refresh
    |-> ##5 rdata_valid) else $error("read done");
  cover property (take && req.refresh);
  cover property (take && req.write);
  cover property (hold_grant && !busy);
endmodule : lane_signalling_checker
bind lane_signalling lane_signalling_checker i_chk (.clk(clk), .arst_n(arst_n),
  .hold_grant(hold_grant), .req(req), .pins(pins), .rdata_valid(rdata_valid), .busy(busy));

//--- tb/lane_far_side.sv
// far side: answers reads with a fixed word, stays off the bus in refresh
module lane_far_side
  import lane_pkg::*;
(
  input  wire logic   clk,
  input  wire pins_t  pins,
  output logic [15:0] ad_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rfsh_q = 0;
  initial ad_i = '0;
  always @(posedge clk) begin
    if (pins.ale) rfsh_q <= pins.lane_o & pins.ad_o[0];
    // driven bus and refresh cycles toggle so a stale value never looks valid
    ad_i <= (pins.ad_oe == '0 && !rfsh_q) ? 16'hc35a : ~ad_i;
  end
endmodule : lane_far_side

//--- tb/lane_signalling_tb_top.sv
// testbench: lane, refresh, size and hold scenarios
module lane_signalling_tb_top
  import lane_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, arst_n = 0, hold_grant = 0, rv, busy, rdv;
  req_t req = '0;
  pins_t pins, t1, t2;
  logic [15:0] ad_i, rd, rdata;
  logic [19:0] nma;
  int n_fail = 0, checks = 0;
  lane_signalling i_dut (.clk(clk), .arst_n(arst_n), .hold_grant(hold_grant), .req(req),
    .ad_i(ad_i), .nonmux_address_bus(nma), .pins(pins), .rdata(rdata), .rdata_valid(rdv),
    .busy(busy));
  lane_far_side i_far (.clk(clk), .pins(pins), .ad_i(ad_i));
  initial forever #25 clk = ~clk;
  task chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // one cycle: t1 and t2 captured, read result one cycle after t4
  task go(input logic w, r, n, input logic [1:0] b);
    req = '{1'b1, w, r, n, b, 20'h01234, 16'h1234};
    @(negedge clk) req.start = 0;
    t1 = pins;
    @(negedge clk) t2 = pins;
    repeat (3) @(negedge clk);
    rv = rdv;
    rd = rdata;
    @(negedge clk);
  endtask : go
  task t_word;
    go(1, 0, 0, 2'b11);
    chk({t1.lane_o, t1.ad_o[0], t2.wr_hi_n, t2.wr_lo_n}, 4'h0);
    chk(nma, 20'h01234);
  endtask : t_word
  task t_high;
    go(1, 0, 0, 2'b10);
    chk({t1.lane_o, t1.ad_o[0], t2.wr_hi_n, t2.wr_lo_n, t2.ad_oe}, 20'h5ff00);
  endtask : t_high
  task t_low;
    go(0, 0, 1, 2'b01);
    chk({t1.lane_o, t1.ad_o[0], t2.narrow_cycle_flag}, 3'h5);
    chk({rv, rd[7:0]}, 9'h15a);
  endtask : t_low
  task t_refresh;
    go(0, 1, 0, 2'b11);
    chk({t1.lane_o, t1.ad_o[0], t2.ad_oe}, 18'h30000);
  endtask : t_refresh
  task t_hold;
    hold_grant = 1;
    go(0, 0, 0, 2'b11);
    chk({t1.lane_oe, t1.ale, t1.ad_oe[0], rv}, 4'h0);
    hold_grant = 0;
  endtask : t_hold
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1;
    @(negedge clk);
    t_word;
    t_high;
    t_low;
    t_refresh;
    t_hold;
    test_done;
  end
  initial begin
    #20us;
    n_fail++;
    test_done;
  end
endmodule : lane_signalling_tb_top
